// ---- shared/crf_pkg.sv ----
package crf_pkg;
   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int NUM_GPR   = 8;
   localparam int GPR_W     = 32;
   localparam int HALF_W    = 16;
   localparam int BYTE_W    = 8;
   localparam int SEL_W     = 3;
   localparam int SP_IDX    = 7;
   localparam int PC_W      = 24;
   localparam int FW_W      = 8;
   localparam int ADDR_1M_W = 20;

   // ----------------------------------------------------------------
   // Flag word bit positions and reset value
   // ----------------------------------------------------------------
   localparam int FB_I  = 7;
   localparam int FB_UI = 6;
   localparam int FB_H  = 5;
   localparam int FB_U  = 4;
   localparam int FB_N  = 3;
   localparam int FB_Z  = 2;
   localparam int FB_V  = 1;
   localparam int FB_C  = 0;
   localparam logic [FW_W-1:0] FW_RST = 8'h80;
   localparam logic [PC_W-1:0] PC_RST = 24'h000000;

   // ----------------------------------------------------------------
   // Operand masks and half-carry bit per size
   // ----------------------------------------------------------------
   localparam logic [31:0] WMASK_B = 32'h000000FF;
   localparam logic [31:0] WMASK_W = 32'h0000FFFF;
   localparam logic [31:0] WMASK_L = 32'hFFFFFFFF;
   localparam logic [31:0] HMASK_B = 32'h0000000F;
   localparam logic [31:0] HMASK_W = 32'h00000FFF;
   localparam logic [31:0] HMASK_L = 32'h0FFFFFFF;
   localparam int HC_B = 3;
   localparam int HC_W = 11;
   localparam int HC_L = 27;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {VW_LONG, VW_EXT, VW_WORD, VW_HBYTE,
                             VW_LBYTE} crf_view_t;
   typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} crf_size_t;
   typedef enum logic [3:0] {AL_NONE, AL_ADD, AL_ADDX, AL_SUB, AL_SUBX,
                             AL_CMP, AL_NEG, AL_LOGIC, AL_SHIFT,
                             AL_BITLD} crf_alu_t;
   typedef enum logic [2:0] {FO_NONE, FO_LOAD, FO_AND, FO_OR,
                             FO_XOR} crf_fwop_t;
   typedef enum logic [3:0] {CC_T, CC_F, CC_HI, CC_LS, CC_CC, CC_CS,
                             CC_NE, CC_EQ, CC_VC, CC_VS, CC_PL, CC_MI,
                             CC_GE, CC_LT, CC_GT, CC_LE} crf_cond_t;
endpackage

// ---- shared/crf_flag_if.sv ----
`timescale 1ns/1ps
interface crf_flag_if;
   import crf_pkg::*;
   crf_alu_t    op;
   crf_size_t   size;
   logic [31:0] a;
   logic [31:0] b;
   logic        ci;
   logic        aux_in;
   logic [31:0] res;
   logic        n;
   logic        z;
   logic        v;
   logic        c;
   logic        h;
   modport core (output op, size, a, b, ci, aux_in,
                 input res, n, z, v, c, h);
   modport unit (input op, size, a, b, ci, aux_in,
                 output res, n, z, v, c, h);
endinterface

// ---- verilog/crf_flag_unit.sv ----
`timescale 1ns/1ps
module crf_flag_unit (
   // Operation and flag results
   crf_flag_if.unit fi
);
   import crf_pkg::*;

   logic [32:0] ax;
   logic [32:0] bx;
   logic [32:0] sum;
   logic [32:0] hs;
   logic [32:0] cin;
   logic [31:0] wm;
   logic [31:0] hm;
   logic        sub;
   logic        arith;
   logic        sa;
   logic        sb;
   logic        cy;
   logic        hc;

   // ----------------------------------------------------------------
   // Arithmetic at the selected width
   // ----------------------------------------------------------------
   always_comb begin
      case (fi.size)
         SZ_BYTE: begin
            wm = WMASK_B;
            hm = HMASK_B;
         end
         SZ_WORD: begin
            wm = WMASK_W;
            hm = HMASK_W;
         end
         default: begin
            wm = WMASK_L;
            hm = HMASK_L;
         end
      endcase
      arith = fi.op inside {AL_ADD, AL_ADDX, AL_SUB, AL_SUBX, AL_CMP,
                            AL_NEG};
      sub   = fi.op inside {AL_SUB, AL_SUBX, AL_CMP, AL_NEG};
      cin   = {32'h00000000,
               fi.ci & (fi.op inside {AL_ADDX, AL_SUBX})};
      ax    = {1'b0, fi.a & wm};
      bx    = {1'b0, fi.b & wm};
      if (fi.op == AL_NEG) begin
         ax = 33'h000000000;
         bx = {1'b0, fi.a & wm};
      end
      sum = sub ? ax - bx - cin : ax + bx + cin;
      hs  = sub ? (ax & {1'b0, hm}) - (bx & {1'b0, hm}) - cin
                : (ax & {1'b0, hm}) + (bx & {1'b0, hm}) + cin;
      fi.res = arith ? (sum[31:0] & wm) : (fi.a & wm);
      case (fi.size)
         SZ_BYTE: begin
            fi.n = fi.res[BYTE_W-1];
            sa   = ax[BYTE_W-1];
            sb   = bx[BYTE_W-1];
            cy   = sum[BYTE_W];
            hc   = hs[HC_B+1];
         end
         SZ_WORD: begin
            fi.n = fi.res[HALF_W-1];
            sa   = ax[HALF_W-1];
            sb   = bx[HALF_W-1];
            cy   = sum[HALF_W];
            hc   = hs[HC_W+1];
         end
         default: begin
            fi.n = fi.res[GPR_W-1];
            sa   = ax[GPR_W-1];
            sb   = bx[GPR_W-1];
            cy   = sum[GPR_W];
            hc   = hs[HC_L+1];
         end
      endcase
      fi.z = (fi.res == 32'h00000000);
      fi.h = hc;
      if (arith) begin
         fi.v = sub ? (sa != sb) && (fi.n != sa)
                    : (sa == sb) && (fi.n != sa);
         fi.c = cy;
      end else begin
         fi.v = 1'b0;
         fi.c = fi.aux_in;
      end
   end
endmodule

// ---- verilog/crf_regfile.sv ----
`timescale 1ns/1ps
// Functional notes
// - eight alike 32-bit general registers.
// - each splits into extended and lower halves.
// - lower half splits into high and low bytes.
// - register seven is the stack pointer.
// - 24-bit program counter holds next fetch address.
// - fetch address always has bit zero cleared.
// - flag word bits I UI H U N Z V C.
// - mask bit blocks interrupts except non-maskable.
// - exception start sets the mask bit.
// - bits six and four freely software accessible.
// - byte arithmetic half-carry from bit three.
// - word arithmetic half-carry from bit eleven.
// - longword arithmetic half-carry from bit 27.
// - negative flag copies result sign bit.
// - zero flag set on zero result.
// - overflow flag set only on overflow.
// - carry from add, borrow, shift, bit ops.
// - only flag-affecting operations, flag word instructions and exception start change flag bits.
// - branch conditions use N, Z, V, C.
// - 1-Mbyte mode keeps only 20 address bits.
// - reset loads PC_RST, sets mask, clears other flag bits; general registers uninitialized.
module crf_regfile #(
   parameter int ADDR_W = crf_pkg::PC_W
) (
   // Clock and reset
   input  wire logic                           clk,
   input  wire logic                           arst_n,
   // Operating mode pin, high selects the 1-Mbyte mode
   input  wire logic                           mode_1mb_pin,
   // General register write port
   input  wire logic                           gpr_wr_en,
   input  wire logic [crf_pkg::SEL_W-1:0]      gpr_wr_sel,
   input  crf_pkg::crf_view_t                  gpr_wr_view,
   input  wire logic [crf_pkg::GPR_W-1:0]      gpr_wr_data,
   // General register read ports
   input  wire logic [crf_pkg::SEL_W-1:0]      rd_a_sel,
   input  crf_pkg::crf_view_t                  rd_a_view,
   output logic [crf_pkg::GPR_W-1:0]           rd_a_data,
   input  wire logic [crf_pkg::SEL_W-1:0]      rd_b_sel,
   input  crf_pkg::crf_view_t                  rd_b_view,
   output logic [crf_pkg::GPR_W-1:0]           rd_b_data,
   // Stack pointer
   output logic [crf_pkg::GPR_W-1:0]           sp_value,
   // Program counter
   input  wire logic                           pc_load,
   input  wire logic [ADDR_W-1:0]              pc_load_val,
   input  wire logic                           pc_adv,
   input  wire logic [ADDR_W-1:0]              pc_step,
   output logic [ADDR_W-1:0]                   pc_value,
   output logic [ADDR_W-1:0]                   fetch_addr,
   // Effective address
   input  wire logic [ADDR_W-1:0]              ea_in,
   output logic [ADDR_W-1:0]                   ea_out,
   // Flag-affecting operation
   input  crf_pkg::crf_alu_t                   alu_op,
   input  crf_pkg::crf_size_t                  alu_size,
   input  wire logic [crf_pkg::GPR_W-1:0]      alu_a,
   input  wire logic [crf_pkg::GPR_W-1:0]      alu_b,
   input  wire logic                           alu_aux,
   output logic [crf_pkg::GPR_W-1:0]           alu_result,
   // Flag word instructions
   input  crf_pkg::crf_fwop_t                  fw_op,
   input  wire logic [crf_pkg::FW_W-1:0]       fw_data,
   output logic [crf_pkg::FW_W-1:0]            flag_word,
   // Exceptions and interrupts
   input  wire logic                           exc_start,
   input  wire logic                           irq_req,
   input  wire logic                           nmi_req,
   output logic                                irq_accept,
   output logic                                aux_mask_bit,
   // Branch condition
   input  crf_pkg::crf_cond_t                  cond_code,
   output logic                                cond_true
);
   import crf_pkg::*;

   if (ADDR_W <= ADDR_1M_W || ADDR_W > GPR_W)
      $error("ADDR_W must lie above 20 and not above 32");

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] MASK_1M =
      {{(ADDR_W-ADDR_1M_W){1'b0}}, {ADDR_1M_W{1'b1}}};

   logic [GPR_W-1:0]  gpr_r [NUM_GPR];
   logic [GPR_W-1:0]  gpr_nxt;
   logic [GPR_W-1:0]  rd_a_r;
   logic [GPR_W-1:0]  rd_a_nxt;
   logic [GPR_W-1:0]  rd_b_r;
   logic [GPR_W-1:0]  rd_b_nxt;
   logic              mode_s1_r;
   logic              mode_s1_nxt;
   logic              mode_s2_r;
   logic              mode_s2_nxt;
   logic [ADDR_W-1:0] pc_r;
   logic [ADDR_W-1:0] pc_nxt;
   logic [ADDR_W-1:0] ea_r;
   logic [ADDR_W-1:0] ea_nxt;
   logic [FW_W-1:0]   fw_r;
   logic [FW_W-1:0]   fw_nxt;
   logic [GPR_W-1:0]  res_r;
   logic [GPR_W-1:0]  res_nxt;
   logic              fl_n;
   logic              fl_z;
   logic              fl_v;
   logic              fl_c;

   crf_flag_if fif ();

   crf_flag_unit u_flag (
      .fi (fif.unit)
   );

   // ----------------------------------------------------------------
   // Views of a general register
   // ----------------------------------------------------------------
   function automatic logic [GPR_W-1:0] view_rd(
      input logic [GPR_W-1:0] w,
      input crf_view_t        vw
   );
      logic [GPR_W-1:0] r;
      r = '0;
      case (vw)
         VW_LONG:  r = w;
         VW_EXT:   r[HALF_W-1:0] = w[GPR_W-1:HALF_W];
         VW_WORD:  r[HALF_W-1:0] = w[HALF_W-1:0];
         VW_HBYTE: r[BYTE_W-1:0] = w[HALF_W-1:BYTE_W];
         VW_LBYTE: r[BYTE_W-1:0] = w[BYTE_W-1:0];
         default:  r = '0;
      endcase
      return r;
   endfunction

   // ----------------------------------------------------------------
   // General registers
   // ----------------------------------------------------------------
   always_comb begin
      gpr_nxt = gpr_r[gpr_wr_sel];
      case (gpr_wr_view)
         VW_LONG:  gpr_nxt = gpr_wr_data;
         VW_EXT:   gpr_nxt[GPR_W-1:HALF_W] =
                      gpr_wr_data[HALF_W-1:0];
         VW_WORD:  gpr_nxt[HALF_W-1:0] =
                      gpr_wr_data[HALF_W-1:0];
         VW_HBYTE: gpr_nxt[HALF_W-1:BYTE_W] =
                      gpr_wr_data[BYTE_W-1:0];
         VW_LBYTE: gpr_nxt[BYTE_W-1:0] =
                      gpr_wr_data[BYTE_W-1:0];
         default:  gpr_nxt = gpr_r[gpr_wr_sel];
      endcase
      rd_a_nxt = view_rd(gpr_r[rd_a_sel], rd_a_view);
      rd_b_nxt = view_rd(gpr_r[rd_b_sel], rd_b_view);
   end

   // The registers carry no reset, so software must set the stack
   // pointer before its first use.
   always_ff @(posedge clk) begin
      if (gpr_wr_en) begin
         gpr_r[gpr_wr_sel] <= gpr_nxt;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_a_r <= '0;
         rd_b_r <= '0;
      end else begin
         rd_a_r <= rd_a_nxt;
         rd_b_r <= rd_b_nxt;
      end
   end

   assign rd_a_data = rd_a_r;
   assign rd_b_data = rd_b_r;
   assign sp_value  = gpr_r[SP_IDX];

   // ----------------------------------------------------------------
   // Mode pin synchroniser
   // ----------------------------------------------------------------
   always_comb begin
      mode_s1_nxt = mode_1mb_pin;
      mode_s2_nxt = mode_s1_r;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mode_s1_r <= 1'b0;
         mode_s2_r <= 1'b0;
      end else begin
         mode_s1_r <= mode_s1_nxt;
         mode_s2_r <= mode_s2_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Program counter and addresses
   // ----------------------------------------------------------------
   always_comb begin
      pc_nxt = pc_r;
      if (pc_load) begin
         pc_nxt = pc_load_val;
      end else if (pc_adv) begin
         pc_nxt = pc_r + pc_step;
      end
      ea_nxt = mode_s2_r ? (ea_in & MASK_1M) : ea_in;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pc_r <= ADDR_W'(PC_RST);
         ea_r <= '0;
      end else begin
         pc_r <= pc_nxt;
         ea_r <= ea_nxt;
      end
   end

   assign pc_value   = pc_r;
   assign ea_out     = ea_r;
   assign fetch_addr = {pc_r[ADDR_W-1:1], 1'b0}
                       & (mode_s2_r ? MASK_1M : '1);

   // ----------------------------------------------------------------
   // Flag word
   // ----------------------------------------------------------------
   assign fif.op     = alu_op;
   assign fif.size   = alu_size;
   assign fif.a      = alu_a;
   assign fif.b      = alu_b;
   assign fif.ci     = fw_r[FB_C];
   assign fif.aux_in = alu_aux;

   always_comb begin
      fw_nxt  = fw_r;
      res_nxt = res_r;
      case (alu_op)
         AL_ADD, AL_ADDX, AL_SUB, AL_SUBX, AL_CMP, AL_NEG: begin
            fw_nxt[FB_H] = fif.h;
            fw_nxt[FB_N] = fif.n;
            fw_nxt[FB_Z] = fif.z;
            fw_nxt[FB_V] = fif.v;
            fw_nxt[FB_C] = fif.c;
            res_nxt      = fif.res;
         end
         AL_LOGIC: begin
            fw_nxt[FB_N] = fif.n;
            fw_nxt[FB_Z] = fif.z;
            fw_nxt[FB_V] = 1'b0;
            res_nxt      = fif.res;
         end
         AL_SHIFT: begin
            fw_nxt[FB_N] = fif.n;
            fw_nxt[FB_Z] = fif.z;
            fw_nxt[FB_V] = 1'b0;
            fw_nxt[FB_C] = fif.c;
            res_nxt      = fif.res;
         end
         AL_BITLD: fw_nxt[FB_C] = fif.c;
         default:  fw_nxt = fw_r;
      endcase
      case (fw_op)
         FO_LOAD: fw_nxt = fw_data;
         FO_AND:  fw_nxt = fw_r & fw_data;
         FO_OR:   fw_nxt = fw_r | fw_data;
         FO_XOR:  fw_nxt = fw_r ^ fw_data;
         default: ;
      endcase
      if (exc_start) begin
         fw_nxt[FB_I] = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         fw_r  <= FW_RST;
         res_r <= '0;
      end else begin
         fw_r  <= fw_nxt;
         res_r <= res_nxt;
      end
   end

   assign flag_word    = fw_r;
   assign alu_result   = res_r;
   assign aux_mask_bit = fw_r[FB_UI];
   assign irq_accept   = nmi_req | (irq_req & ~fw_r[FB_I]);

   // ----------------------------------------------------------------
   // Branch conditions
   // ----------------------------------------------------------------
   assign fl_n = fw_r[FB_N];
   assign fl_z = fw_r[FB_Z];
   assign fl_v = fw_r[FB_V];
   assign fl_c = fw_r[FB_C];

   always_comb begin
      case (cond_code)
         CC_T:    cond_true = 1'b1;
         CC_F:    cond_true = 1'b0;
         CC_HI:   cond_true = ~(fl_c | fl_z);
         CC_LS:   cond_true = fl_c | fl_z;
         CC_CC:   cond_true = ~fl_c;
         CC_CS:   cond_true = fl_c;
         CC_NE:   cond_true = ~fl_z;
         CC_EQ:   cond_true = fl_z;
         CC_VC:   cond_true = ~fl_v;
         CC_VS:   cond_true = fl_v;
         CC_PL:   cond_true = ~fl_n;
         CC_MI:   cond_true = fl_n;
         CC_GE:   cond_true = ~(fl_n ^ fl_v);
         CC_LT:   cond_true = fl_n ^ fl_v;
         CC_GT:   cond_true = ~(fl_z | (fl_n ^ fl_v));
         CC_LE:   cond_true = fl_z | (fl_n ^ fl_v);
         default: cond_true = 1'b0;
      endcase
   end
endmodule

// ---- verif/crf_regfile_props.sv ----
`timescale 1ns/1ps
module crf_regfile_chk #(
   parameter int ADDR_W = 24
) (
   // Clock and reset
   input wire logic              clk,
   input wire logic              arst_n,
   // Watched ports
   input wire logic              mode_1mb_pin,
   input wire logic              pc_load,
   input wire logic [ADDR_W-1:0] pc_load_val,
   input wire logic [ADDR_W-1:0] pc_value,
   input wire logic [ADDR_W-1:0] fetch_addr,
   input wire logic [ADDR_W-1:0] ea_out,
   input crf_pkg::crf_alu_t      alu_op,
   input crf_pkg::crf_size_t     alu_size,
   input wire logic [31:0]       alu_a,
   input wire logic [31:0]       alu_b,
   input wire logic [31:0]       alu_result,
   input crf_pkg::crf_fwop_t     fw_op,
   input wire logic [7:0]        flag_word,
   input wire logic              exc_start,
   input wire logic              irq_req,
   input wire logic              nmi_req,
   input wire logic              irq_accept,
   input wire logic              aux_mask_bit,
   input crf_pkg::crf_cond_t     cond_code,
   input wire logic              cond_true
);
   import crf_pkg::*;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   logic sets_nz;
   function automatic logic [31:0] msk(crf_size_t s);
      return (s == SZ_BYTE) ? WMASK_B : (s == SZ_WORD) ? WMASK_W : WMASK_L;
   endfunction
   assign sets_nz = fw_op == FO_NONE && alu_op inside {AL_ADD, AL_ADDX,
      AL_SUB, AL_SUBX, AL_CMP, AL_NEG, AL_LOGIC, AL_SHIFT};
   a_fetch_even_addr: assert property (fetch_addr[0] == 1'b0)
      else $error("fetch address is odd");
   a_irq_gate_mask: assert property (irq_accept == (nmi_req |
      (irq_req & ~flag_word[FB_I]))) else $error("interrupt gate wrong");
   a_exc_sets_mask: assert property (exc_start |=> flag_word[FB_I])
      else $error("mask bit not set by exception");
   a_aux_bit_mirror: assert property (aux_mask_bit ==
      flag_word[FB_UI]) else $error("aux mask output differs from flag word");
   a_byte_half_carry: assert property (alu_op == AL_ADD &&
      alu_size == SZ_BYTE && fw_op == FO_NONE |=> flag_word[FB_H] ==
      ($past(alu_a[3:0]) + $past(alu_b[3:0]) > 5'h0F))
      else $error("byte half carry wrong");
   a_neg_from_sign: assert property (sets_nz |=> flag_word[FB_N] ==
      |(alu_result & msk($past(alu_size)) & ~(msk($past(alu_size)) >> 1)))
      else $error("negative flag differs from sign");
   a_zero_from_result: assert property (sets_nz |=>
      flag_word[FB_Z] == ((alu_result & msk($past(alu_size))) == 32'h0))
      else $error("zero flag differs from result");
   a_idle_keeps_flags: assert property (alu_op == AL_NONE &&
      fw_op == FO_NONE && !exc_start |=> $stable(flag_word))
      else $error("flag word changed without cause");
   a_pc_load_value: assert property (pc_load |=>
      pc_value == $past(pc_load_val)) else $error("program counter load lost");
   a_one_mb_mask: assert property ($past(mode_1mb_pin, 2) &&
      $past(mode_1mb_pin, 3) && $past(mode_1mb_pin, 4) && $past(arst_n, 4)
      |-> ea_out[ADDR_W-1:ADDR_1M_W] == '0 &&
      fetch_addr[ADDR_W-1:ADDR_1M_W] == '0) else $error("upper address kept");
   a_cond_equal: assert property (cond_code == CC_EQ |->
      cond_true == flag_word[FB_Z]) else $error("equal condition wrong");
   c_exception: cover property (exc_start);
   c_nmi_masked: cover property (nmi_req && flag_word[FB_I] && irq_accept);
   c_byte_add: cover property (alu_op == AL_ADD && alu_size == SZ_BYTE);
endmodule

bind crf_regfile crf_regfile_chk #(.ADDR_W(ADDR_W)) u_crf_regfile_chk (.*);

// ---- verif/crf_exc_model.sv ----
`timescale 1ns/1ps
module crf_exc_model (
   // Clock and reset
   input  wire logic clk,
   input  wire logic arst_n,
   // Commands from the bench
   input  wire logic exc_go,
   input  wire logic irq_lvl,
   input  wire logic nmi_lvl,
   // Requests toward the register file
   output logic      exc_start,
   output logic      irq_req,
   output logic      nmi_req
);
   logic go_r, exc_r, irq_r, nmi_r, go_nxt, exc_nxt, irq_nxt, nmi_nxt;
   always_comb begin
      go_nxt  = exc_go;
      // A held command still opens only one exception sequence.
      exc_nxt = exc_go & ~go_r;
      irq_nxt = irq_lvl;
      nmi_nxt = nmi_lvl;
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         {go_r, exc_r, irq_r, nmi_r} <= 4'h0;
      end else begin
         {go_r, exc_r, irq_r, nmi_r} <= {go_nxt, exc_nxt, irq_nxt, nmi_nxt};
      end
   end
   assign exc_start = exc_r;
   assign irq_req   = irq_r;
   assign nmi_req   = nmi_r;
endmodule

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
module testbench;
   import crf_pkg::*;
   localparam int AW = 24;
   logic clk, arst_n, mode_1mb_pin, gpr_wr_en, pc_load, pc_adv, alu_aux;
   logic exc_go, irq_lvl, nmi_lvl, exc_start, irq_req, nmi_req;
   logic irq_accept, aux_mask_bit, cond_true;
   logic [2:0]    gpr_wr_sel, rd_a_sel, rd_b_sel;
   logic [31:0]   gpr_wr_data, rd_a_data, rd_b_data, sp_value;
   logic [31:0]   alu_a, alu_b, alu_result;
   logic [AW-1:0] pc_load_val, pc_step, pc_value, fetch_addr, ea_in, ea_out;
   logic [7:0]    fw_data, flag_word;
   crf_view_t     gpr_wr_view = VW_LONG, rd_a_view = VW_LONG;
   crf_view_t     rd_b_view = VW_LONG;
   crf_alu_t      alu_op = AL_NONE;
   crf_size_t     alu_size = SZ_BYTE;
   crf_fwop_t     fw_op = FO_NONE;
   crf_cond_t     cond_code = CC_T;
   int            fail_count, total_checks, cycles;
   typedef struct packed {
      logic [7:0] init; crf_alu_t op; crf_size_t size; logic [31:0] a;
      logic [31:0] b; logic aux; logic [31:0] res; logic [7:0] fw;
   } crf_row_t;
   crf_row_t rows [15] = '{
      '{8'h00, AL_ADD, SZ_BYTE, 32'h0F, 32'h1, 1'b0, 32'h10, 8'h20},
      '{8'h00, AL_ADD, SZ_BYTE, 32'h7F, 32'h1, 1'b0, 32'h80, 8'h2A},
      '{8'h00, AL_ADD, SZ_BYTE, 32'hFF, 32'h1, 1'b0, 32'h00, 8'h25},
      '{8'h00, AL_ADD, SZ_WORD, 32'hFFF, 32'h1, 1'b0, 32'h1000, 8'h20},
      '{8'h00, AL_ADD, SZ_WORD, 32'hF, 32'h1, 1'b0, 32'h10, 8'h00},
      '{8'h00, AL_ADD, SZ_LONG, 32'hFFFFFFF, 32'h1, 1'b0, 32'h10000000,
        8'h20},
      '{8'h00, AL_SUB, SZ_BYTE, 32'h0, 32'h1, 1'b0, 32'hFF, 8'h29},
      '{8'h00, AL_SUB, SZ_LONG, 32'h80000000, 32'h1, 1'b0, 32'h7FFFFFFF,
        8'h22},
      '{8'h00, AL_CMP, SZ_WORD, 32'h5, 32'h5, 1'b0, 32'h0, 8'h04},
      '{8'h00, AL_NEG, SZ_BYTE, 32'h1, 32'h1, 1'b0, 32'hFF, 8'h29},
      '{8'h01, AL_ADDX, SZ_BYTE, 32'hE, 32'h1, 1'b0, 32'h10, 8'h20},
      '{8'h01, AL_SUBX, SZ_BYTE, 32'h10, 32'hF, 1'b0, 32'h0, 8'h24},
      '{8'h13, AL_LOGIC, SZ_BYTE, 32'h80, 32'h0, 1'b0, 32'h80, 8'h19},
      '{8'h5A, AL_BITLD, SZ_BYTE, 32'h0, 32'h0, 1'b1, 32'h80, 8'h5B},
      '{8'h00, AL_SHIFT, SZ_WORD, 32'h8000, 32'h0, 1'b1, 32'h8000,
        8'h09}};
   crf_view_t   vw [5] = '{VW_LONG, VW_EXT, VW_WORD, VW_HBYTE, VW_LBYTE};
   logic [31:0] vx [5] = '{32'h12345678, 32'h1234, 32'h5678, 32'h56, 32'h78};
   crf_fwop_t   fo [4] = '{FO_LOAD, FO_OR, FO_AND, FO_XOR};
   logic [7:0]  fd [4] = '{8'h00, 8'h50, 8'h40, 8'h41};
   logic [7:0]  fx [4] = '{8'h00, 8'h50, 8'h40, 8'h01};

   crf_regfile #(.ADDR_W(AW)) u_crf_regfile (.*);
   crf_exc_model u_crf_exc_model (.*);

   task automatic step();
      @(posedge clk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         close_out();
      end
   end

   initial begin
      {arst_n, mode_1mb_pin, gpr_wr_en, pc_load, pc_adv, alu_aux} = 6'h0;
      {exc_go, irq_lvl, nmi_lvl, gpr_wr_sel, rd_a_sel, rd_b_sel} = 12'h0;
      {gpr_wr_data, alu_a, alu_b, fw_data} = 104'h0;
      {pc_load_val, pc_step, ea_in} = 72'h0;
      repeat (10) step();
      arst_n = 1'b1;
      foreach (rows[i]) begin
         fw_op = FO_LOAD;
         fw_data = rows[i].init;
         step();
         fw_op = FO_NONE;
         alu_op = rows[i].op;
         alu_size = rows[i].size;
         {alu_a, alu_b, alu_aux} = {rows[i].a, rows[i].b, rows[i].aux};
         step();
         alu_op = AL_NONE;
         chk("alu_result", alu_result, rows[i].res);
         chk("flag_word", 32'(flag_word), 32'(rows[i].fw));
      end
      $display("test flag rows done");
      {pc_load, pc_load_val} = {1'b1, 24'h001235};
      step();
      {pc_load, pc_adv, pc_step} = {1'b0, 1'b1, 24'h000002};
      chk("pc_value", 32'(pc_value), 32'h1235);
      chk("fetch_addr", 32'(fetch_addr), 32'h1234);
      step();
      chk("fetch_addr", 32'(fetch_addr), 32'h1236);
      {pc_load, pc_load_val} = {1'b1, 24'h000101};
      step();
      chk("pc_value", 32'(pc_value), 32'h101);
      {pc_adv, mode_1mb_pin, ea_in, pc_load_val} = {2'b01, 24'hFFFFFF, 24'hABCDE5};
      repeat (4) step();
      chk("fetch_addr", 32'(fetch_addr), 32'hBCDE4);
      chk("ea_out", 32'(ea_out), 32'h0FFFFF);
      {pc_load, mode_1mb_pin} = 2'b00;
      repeat (4) step();
      chk("ea_out", 32'(ea_out), 32'hFFFFFF);
      $display("test program counter done");
      arst_n = 1'b0;
      #1;
      chk("flag_word", 32'(flag_word), 32'h80);
      chk("pc_value", 32'(pc_value), 32'h0);
      chk("alu_result", alu_result, 32'h0);
      step();
      arst_n = 1'b1;
      gpr_wr_en = 1'b1;
      for (int r = 7; r >= 0; r--) begin
         {gpr_wr_sel, gpr_wr_data} = {3'(r), {8{4'(r + 8)}}};
         step();
      end
      for (int i = 0; i < 4; i++) begin
         gpr_wr_sel = (i == 3) ? 3'h2 : 3'h3;
         gpr_wr_view = (i == 0) ? VW_EXT : (i == 1) ? VW_HBYTE :
            (i == 2) ? VW_LBYTE : VW_WORD;
         gpr_wr_data = (i == 0) ? 32'hFFFF1234 : (i == 1) ? 32'hFFFFFF56 :
            (i == 2) ? 32'hFFFFFF78 : 32'hFFFF0C0D;
         step();
      end
      gpr_wr_en = 1'b0;
      chk("sp_value", sp_value, 32'hFFFFFFFF);
      for (int r = 0; r < 8; r++) begin
         rd_a_sel = 3'(r);
         step();
         if (r != 2 && r != 3) chk("rd_a_data", rd_a_data, {8{4'(r + 8)}});
      end
      rd_a_sel = 3'h3;
      rd_b_sel = 3'h2;
      for (int i = 0; i < 5; i++) begin
         rd_a_view = vw[i];
         step();
         chk("rd_a_data", rd_a_data, vx[i]);
         chk("rd_b_data", rd_b_data, 32'hAAAA0C0D);
      end
      $display("test general registers done");
      for (int i = 0; i < 4; i++) begin
         fw_op = fo[i];
         fw_data = fd[i];
         step();
         chk("flag_word", 32'(flag_word), 32'(fx[i]));
         chk("aux_mask_bit", 32'(aux_mask_bit), 32'(fx[i][6]));
      end
      fw_op = FO_NONE;
      irq_lvl = 1'b1;
      repeat (2) step();
      chk("irq_accept", 32'(irq_accept), 32'h1);
      exc_go = 1'b1;
      step();
      fw_op = FO_LOAD;
      fw_data = 8'h00;
      step();
      fw_op = FO_NONE;
      chk("flag_word", 32'(flag_word), 32'h80);
      chk("irq_accept", 32'(irq_accept), 32'h0);
      {exc_go, nmi_lvl} = 2'b01;
      repeat (2) step();
      chk("irq_accept", 32'(irq_accept), 32'h1);
      $display("test flag word and interrupts done");
      for (int k = 0; k < 2; k++) begin
         fw_op = FO_LOAD;
         fw_data = (k == 0) ? 8'h04 : 8'h09;
         step();
         fw_op = FO_NONE;
         for (int c = 0; c < 16; c++) begin
            cond_code = crf_cond_t'(c);
            #1;
            chk("cond_true", 32'(cond_true),
               32'(((k == 0) ? 16'h9599 : 16'hA969) >> c & 1));
         end
      end
      $display("test branch conditions done");
      close_out();
   end
endmodule
